// ===== interrupt_driven_transfer_descriptors_tb_top.sv
// self-checking testbench of the transfer engine
`timescale 1ns/1ps
module interrupt_driven_transfer_descriptors_tb_top import te_pkg::*; ;
   logic hclk = 1'b0;
   logic hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, insn_done, insn_ext, stack_ext, cpu_irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, wait_states;
   logic [2:0] hsize;
   logic [NSRC-1:0] src_req, xfer_enable, req_clear;
   logic [4:0] irq_source;
   logic mem_req, mem_we, mem_word;
   logic [15:0] mem_addr, mem_wdata, mem_rdata, w;
   logic [7:0] d [3];
   logic [31:0] exp_wr [$];
   logic [31:0] exp_irq [$];
   logic [31:0] exp_lat [$];
   int tr = 0;
   logic srq_q = 1'b0;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int t0 = 0;
   logic armed = 1'b0;
   logic req_q = 1'b0;
   always #2.5 hclk = ~hclk;
   assign hready = hreadyout;
   te_engine u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .src_req(src_req), .xfer_enable(xfer_enable), .insn_done(insn_done), .insn_ext(insn_ext),
      .stack_ext(stack_ext), .wait_states(wait_states), .req_clear(req_clear), .cpu_irq(cpu_irq),
      .irq_source(irq_source), .mem_req(mem_req), .mem_addr(mem_addr), .mem_we(mem_we), .mem_word(mem_word),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   te_mem_model u_mem (.hclk(hclk), .mem_req(mem_req), .mem_addr(mem_addr), .mem_we(mem_we),
      .mem_word(mem_word), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   // ==========================================
   // checking and closing
   task end_sim;
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task cmp(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t got %0h exp %0h", $time, g, e);
      end
   endtask
   task chk_rd(input logic [31:0] g, input logic [31:0] e); cmp(g, e); endtask
   task chk_wr(input logic [31:0] g); cmp(g, exp_wr.size() != 0 ? exp_wr.pop_front() : 'x); endtask
   task chk_irq(input logic [31:0] g); cmp(g, exp_irq.size() != 0 ? exp_irq.pop_front() : 'x); endtask
   task chk_lat(input logic [31:0] g); cmp(g, exp_lat.size() != 0 ? exp_lat.pop_front() : 'x); endtask
   // ==========================================
   // bus and stimulus tasks
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task put(input logic [15:0] a, input logic [15:0] v);
      u_mem.mem[a] = v[15:8];
      u_mem.mem[a + 16'h0001] = v[7:0];
   endtask
   task fire(input int s);
      @(posedge hclk);
      src_req[s] <= 1'b1;
      armed = 1'b1;
      do @(posedge hclk); while (req_clear[s] !== 1'b1);
      src_req[s] <= 1'b0;
      do ahb(1'b0, REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
   endtask
   // ==========================================
   // result watcher and timeout
   always @(posedge hclk) begin
      cyc++;
      if (src_req !== '0 && !srq_q)
         tr = cyc;
      if (armed && mem_req === 1'b1 && !req_q) begin
         t0 = cyc;
         armed = 1'b0;
         chk_lat(32'(cyc - tr));
      end
      if (mem_req === 1'b1 && !req_q && mem_we === 1'b1)
         chk_wr({mem_addr, mem_word ? mem_wdata : {8'h00, mem_wdata[7:0]}});
      if (cpu_irq === 1'b1)
         chk_irq({16'(cyc - t0), 11'h000, irq_source});
      req_q = mem_req;
      srq_q = (src_req !== '0);
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = 3'h2;
      hwdata = '0; src_req = '0; xfer_enable = '0; insn_done = 1'b1; insn_ext = 1'b0;
      stack_ext = 1'b0; wait_states = 2'h0;
      void'($urandom(32'hC3B1235C));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      stack_ext <= 1'($urandom);
      wait_states <= 2'($urandom);
      foreach (d[i]) d[i] = 8'($urandom);
      ahb(1'b0, REG_CTRL, 32'h0);
      chk_rd(rd, 32'h0);
      ahb(1'b0, 8'h0C, 32'h0);
      chk_rd(rd, 32'h0);
      put(16'h00AA, 16'hFD80);
      put(16'hFD80, 16'h2000);
      put(16'hFD82, 16'hFF88);
      put(16'hFD84, 16'hFE00);
      put(16'hFD86, 16'h0002);
      xfer_enable <= 17'h11000;
      ahb(1'b1, REG_CTRL, 32'h1);
      ahb(1'b0, REG_CTRL, 32'h0);
      chk_rd(rd, 32'h1);
      // third pass leaves count unreloaded: zero restarts as a full count
      // first pass never ends its instruction, third fetches it externally
      for (int i = 0; i < 3; i++) begin
         u_mem.mem[16'hFF88] = d[i];
         insn_done <= 1'(i == 1);
         insn_ext <= 1'(i == 2);
         exp_lat.push_back(i == 1 ? 32'h5 : i == 0 ? 32'h2A
            : 32'h4E + 32'h10 * {30'h0, wait_states});
         exp_wr.push_back({16'hFE00 + 16'(i), 8'h00, d[i]});
         exp_wr.push_back({16'hFD84, 16'hFE01 + 16'(i)});
         exp_wr.push_back({16'hFD86, 16'h0001 - 16'(i)});
         if (i == 1)
            exp_irq.push_back({16'h0020, 11'h000, 5'h0C});
         fire(12);
      end
      insn_done <= 1'b1;
      insn_ext <= 1'b0;
      chk_rd(32'(rd[12:8]), 32'h0C);
      w = 16'($urandom);
      put(16'h0170, {d[0], d[1]});
      put(16'h0172, 16'h8000);
      put(16'h8000, 16'hE000);
      put(16'h8002, 16'h9000);
      put(16'h8004, 16'hFF90);
      put(16'h8006, 16'h0001);
      put(16'h9000, w);
      ahb(1'b1, REG_CTRL, 32'h3);
      exp_wr.push_back({16'h8002, 16'h9002});
      exp_wr.push_back({16'hFF90, w});
      exp_wr.push_back({16'h8004, 16'hFF92});
      exp_wr.push_back({16'h8006, 16'h0000});
      exp_irq.push_back({16'h0045, 11'h000, 5'h10});
      exp_lat.push_back(32'h5);
      fire(16);
      src_req[0] <= 1'b1;
      repeat (40) @(posedge hclk);
      src_req[0] <= 1'b0;
      ahb(1'b0, REG_DONE, 32'h0);
      chk_rd(32'(rd[15:0]), 32'h4);
      chk_rd(32'(exp_wr.size() + exp_irq.size() + exp_lat.size()), 32'h0);
      end_sim();
   end
endmodule

// ===== te_acc_if.sv
// access request bundle between engine and memory access unit
`timescale 1ns/1ps
interface te_acc_if;
   logic start;
   logic [15:0] addr;
   logic we;
   logic word;
   logic [15:0] wdata;
   logic [7:0] cost;
   logic done;
   logic [15:0] rdata;
   modport eng(output start, addr, we, word, wdata, cost, input done, rdata);
   modport unit(input start, addr, we, word, wdata, cost, output done, rdata);
endinterface

// ===== te_access.sv
// memory access unit: holds one access on the memory port for its state count
`timescale 1ns/1ps
module te_access import te_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   te_acc_if.unit acc,
   output logic mem_req,
   output logic [15:0] mem_addr,
   output logic mem_we,
   output logic mem_word,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata
);
   logic [7:0] left_q;

   // ==========================================
   // access sequencing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_req <= 1'b0;
         mem_addr <= 16'h0000;
         mem_we <= 1'b0;
         mem_word <= 1'b0;
         mem_wdata <= 16'h0000;
         left_q <= 8'h00;
      end else if (ce) begin
         if (acc.start) begin
            mem_req <= 1'b1;
            mem_addr <= acc.addr;
            mem_we <= acc.we;
            mem_word <= acc.word;
            mem_wdata <= acc.wdata;
            left_q <= acc.cost - ONE8;
         end else if (mem_req && left_q == 8'h00) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
         end else if (mem_req) begin
            left_q <= left_q - ONE8;
         end
      end
   end

   assign acc.done = ce && mem_req && left_q == 8'h00;
   assign acc.rdata = mem_rdata;
endmodule

// ===== te_engine.sv
// interrupt-started transfer engine with AHB-Lite control registers
//
// Functional notes
// - Pointer table follows the exception vectors, one entry per capable source.
// - Each pointer gives that source's descriptor address anywhere in page 0.
// - Minimum mode two-byte entry; maximum mode four bytes, last two used.
// - Slots from H'0080 step two; maximum mode doubles; last is conversion done.
// - Descriptor is mode word, source, destination, remaining count, consecutive words.
// - On-chip descriptor transfer takes 26 plus steps plus data read and write states.
// - On-chip data access costs 2 states; external or register field word 6.
// - H'FF80 to H'FFFF is register field, not timed as RAM.
// - External descriptors add 20, plus 4 per enabled step.
// - Request costs 2 states of priority decision, then waits for instruction end.
// - Instruction wait bound is 38 on-chip or 74 plus 16m external.
// - Handler entry takes 16 or 21 on-chip, 28+6m or 41+10m external.
// - One transfer per enabled request; interrupt after the final item.
// - Engine clears the source's pending request during the transfer.
// - Mode H'2000 gives bytes, fixed source, stepping destination.
// - Two-byte pointer is read high byte first from the lower address.
// - Mode bit 15 size, bit 14 source step, bit 13 destination step.
// - Order: pointer, mode, source, data, destination, write, count, interrupt.
// - Engine never clears a transfer enable bit.
// - Stored count zero means 65,536 transfers.
`timescale 1ns/1ps
module te_engine import te_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NSRC-1:0] src_req,
   input wire logic [NSRC-1:0] xfer_enable,
   input wire logic insn_done,
   input wire logic insn_ext,
   input wire logic stack_ext,
   input wire logic [1:0] wait_states,
   output logic [NSRC-1:0] req_clear,
   output logic cpu_irq,
   output logic [4:0] irq_source,
   output logic mem_req,
   output logic [15:0] mem_addr,
   output logic mem_we,
   output logic mem_word,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata
);
   typedef enum logic [3:0] {
      S_IDLE, S_ARB, S_INSN, S_PTR, S_MODE, S_SRC, S_RDATA, S_WBSRC,
      S_DST, S_WDATA, S_WBDST, S_CNT, S_WBCNT, S_PAD, S_HAND
   } te_state_e;

   te_state_e st_q;
   logic [1:0] ctrl_q;
   logic [7:0] a_addr_q;
   logic a_wr_q;
   logic [4:0] sel_q;
   logic [4:0] last_src_q;
   logic [7:0] cnt_q;
   logic [7:0] elap_q;
   logic issued_q;
   logic [15:0] desc_q;
   logic [15:0] mode_q;
   logic [15:0] src_q;
   logic [15:0] dst_q;
   logic [15:0] data_q;
   logic [15:0] rem_q;
   logic [15:0] done_cnt_q;
   logic [NSRC-1:0] pend;
   logic [4:0] pick;
   logic acc_st;
   logic w, si, di, dext, maxm;
   logic [15:0] step;
   logic [7:0] budget, insn_lim, hand_lim;
   logic [1:0] ctrl_now;
   logic [31:0] rd_mux;

   te_acc_if acc();

   te_access u_acc (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .acc(acc),
      .mem_req(mem_req),
      .mem_addr(mem_addr),
      .mem_we(mem_we),
      .mem_word(mem_word),
      .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata)
   );

   // ==========================================
   // AHB-Lite slave
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_wr_q <= 1'b0;
         a_addr_q <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         a_wr_q <= hsel && hready && htrans[1] && hwrite;
         a_addr_q <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // control register: enable and address mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         ctrl_q <= CTRL_RESET;
      else if (ce && a_wr_q && a_addr_q == REG_CTRL)
         ctrl_q <= hwdata[1:0];
   end

   // read data, bypassing a control write still in its data phase
   always_comb begin
      ctrl_now = (a_wr_q && a_addr_q == REG_CTRL) ? hwdata[1:0] : ctrl_q;
      rd_mux = 32'h0000_0000;
      case (haddr[7:0])
         REG_CTRL: rd_mux = {30'h0000_0000, ctrl_now};
         REG_STATUS: rd_mux = {19'h0_0000, last_src_q, 7'h00, st_q != S_IDLE};
         REG_DONE: rd_mux = {16'h0000, done_cnt_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (ce && hsel && hready && htrans[1] && !hwrite)
         hrdata <= rd_mux;
   end

   // ==========================================
   // request selection and derived figures
   always_comb begin
      pend = src_req & xfer_enable & {NSRC{ctrl_q[CTRL_EN_BIT]}};
      pick = SRC_LAST;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (pend[i])
            pick = 5'(i);
      end
   end

   assign maxm = ctrl_q[CTRL_MAX_BIT];
   assign w = mode_q[MODE_SIZE_BIT];
   assign si = mode_q[MODE_SI_BIT];
   assign di = mode_q[MODE_DI_BIT];
   assign step = w ? STEP_WORD : STEP_BYTE;
   assign dext = !is_onchip(desc_q);

   always_comb begin
      budget = ST_BASE + (si ? ST_STEP : 8'h00) + (di ? ST_STEP : 8'h00);
      budget = budget + acc_cost(src_q, w) + acc_cost(dst_q, w);
      if (dext)
         budget = budget + EXT_BASE + (si ? EXT_STEP : 8'h00) + (di ? EXT_STEP : 8'h00);
      insn_lim = insn_ext ? INSN_EXT_BASE + INSN_EXT_M * {6'h00, wait_states} : INSN_ONCHIP;
      if (stack_ext)
         hand_lim = maxm ? HND_MAX_EXT + HND_MAX_EXT_M * {6'h00, wait_states}
                         : HND_MIN_EXT + HND_MIN_EXT_M * {6'h00, wait_states};
      else
         hand_lim = maxm ? HND_MAX_ON : HND_MIN_ON;
   end

   // ==========================================
   // access request per state
   always_comb begin
      acc_st = 1'b1;
      acc.addr = desc_q;
      acc.we = 1'b0;
      acc.word = 1'b1;
      acc.wdata = 16'h0000;
      acc.cost = ACC_ONCHIP;
      case (st_q)
         S_PTR: acc.addr = maxm ? (slot_min(sel_q) << 1) + PTR_MAX_SKIP : slot_min(sel_q);
         S_MODE: acc.addr = desc_q + DESC_MODE;
         S_SRC: acc.addr = desc_q + DESC_SRC;
         S_RDATA: begin
            acc.addr = src_q;
            acc.word = w;
            acc.cost = acc_cost(src_q, w);
         end
         S_WBSRC: begin
            acc.addr = desc_q + DESC_SRC;
            acc.we = 1'b1;
            acc.wdata = src_q;
         end
         S_DST: acc.addr = desc_q + DESC_DST;
         S_WDATA: begin
            acc.addr = dst_q;
            acc.we = 1'b1;
            acc.word = w;
            acc.wdata = data_q;
            acc.cost = acc_cost(dst_q, w);
         end
         S_WBDST: begin
            acc.addr = desc_q + DESC_DST;
            acc.we = 1'b1;
            acc.wdata = dst_q;
         end
         S_CNT: acc.addr = desc_q + DESC_CNT;
         S_WBCNT: begin
            acc.addr = desc_q + DESC_CNT;
            acc.we = 1'b1;
            acc.wdata = rem_q;
         end
         default: acc_st = 1'b0;
      endcase
      acc.start = ce && acc_st && !issued_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         issued_q <= 1'b0;
      else if (ce && acc.start)
         issued_q <= 1'b1;
      else if (acc.done)
         issued_q <= 1'b0;
   end

   // ==========================================
   // sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= S_IDLE;
         cnt_q <= 8'h00;
         elap_q <= 8'h00;
         sel_q <= 5'h00;
      end else if (ce) begin
         elap_q <= elap_q + ONE8;
         cnt_q <= cnt_q + ONE8;
         case (st_q)
            S_IDLE: begin
               cnt_q <= 8'h00;
               if (|pend) begin
                  sel_q <= pick;
                  st_q <= S_ARB;
               end
            end
            S_ARB: if (cnt_q == ARB_STATES - ONE8) begin
               cnt_q <= 8'h00;
               st_q <= S_INSN;
            end
            S_INSN: if (insn_done || cnt_q >= insn_lim - ONE8) begin
               elap_q <= 8'h00;
               st_q <= S_PTR;
            end
            S_PTR: if (acc.done) st_q <= S_MODE;
            S_MODE: if (acc.done) st_q <= S_SRC;
            S_SRC: if (acc.done) st_q <= S_RDATA;
            S_RDATA: if (acc.done) st_q <= si ? S_WBSRC : S_DST;
            S_WBSRC: if (acc.done) st_q <= S_DST;
            S_DST: if (acc.done) st_q <= S_WDATA;
            S_WDATA: if (acc.done) st_q <= di ? S_WBDST : S_CNT;
            S_WBDST: if (acc.done) st_q <= S_CNT;
            S_CNT: if (acc.done) st_q <= S_WBCNT;
            S_WBCNT: if (acc.done) st_q <= S_PAD;
            S_PAD: if (elap_q >= budget - ONE8) begin
               cnt_q <= 8'h00;
               st_q <= (rem_q == 16'h0000) ? S_HAND : S_IDLE;
            end
            S_HAND: if (cnt_q >= hand_lim - ONE8) st_q <= S_IDLE;
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // ==========================================
   // descriptor datapath
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         desc_q <= 16'h0000;
         mode_q <= 16'h0000;
         src_q <= 16'h0000;
         dst_q <= 16'h0000;
         data_q <= 16'h0000;
         rem_q <= 16'h0000;
      end else if (acc.done) begin
         case (st_q)
            S_PTR: desc_q <= acc.rdata;
            S_MODE: mode_q <= acc.rdata;
            S_SRC: src_q <= acc.rdata;
            S_RDATA: begin
               data_q <= acc.rdata;
               if (si)
                  src_q <= src_q + step;
            end
            S_DST: dst_q <= acc.rdata;
            S_WDATA: if (di) dst_q <= dst_q + step;
            S_CNT: rem_q <= acc.rdata - CNT_DEC;
            default: rem_q <= rem_q;
         endcase
      end
   end

   // ==========================================
   // request clear, completion interrupt, status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_clear <= '0;
         cpu_irq <= 1'b0;
         irq_source <= 5'h00;
         last_src_q <= 5'h00;
         done_cnt_q <= 16'h0000;
      end else if (ce) begin
         req_clear <= '0;
         cpu_irq <= 1'b0;
         if (st_q == S_RDATA && acc.done)
            req_clear[sel_q] <= 1'b1;
         if (st_q == S_PAD && elap_q >= budget - ONE8) begin
            last_src_q <= sel_q;
            done_cnt_q <= done_cnt_q + CNT_DEC;
            if (rem_q == 16'h0000) begin
               cpu_irq <= 1'b1;
               irq_source <= sel_q;
            end
         end
      end
   end
endmodule

// ===== te_engine_monitor.sv
// assertion checker for the engine's memory port and request outputs
`timescale 1ns/1ps
module te_engine_monitor import te_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [NSRC-1:0] xfer_enable,
   input wire logic [NSRC-1:0] req_clear,
   input wire logic cpu_irq,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic mem_we,
   input wire logic mem_word,
   input wire logic [15:0] mem_wdata
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================
   // helpers
   logic [15:0] last_w_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         last_w_q <= 16'hFFFF;
      else if (mem_req && mem_we)
         last_w_q <= mem_wdata;
   end
   sequence s_hold2; mem_req [*2] ##1 !mem_req; endsequence
   sequence s_hold3; mem_req [*3] ##1 !mem_req; endsequence
   sequence s_hold6; mem_req [*6] ##1 !mem_req; endsequence
   // ==========================================
   // properties
   property p_ram_two; $rose(mem_req) && mem_addr >= RAM_LO && mem_addr <= RAM_HI |-> s_hold2; endproperty
   property p_rf_word; $rose(mem_req) && mem_addr >= 16'hFF80 && mem_word |-> s_hold6; endproperty
   property p_rf_byte; $rose(mem_req) && mem_addr >= 16'hFF80 && !mem_word |-> s_hold3; endproperty
   property p_stable;
      mem_req && $past(mem_req) |-> $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
   endproperty
   property p_clr_onehot; req_clear != '0 |-> $onehot(req_clear); endproperty
   property p_clr_enabled; req_clear != '0 |-> (req_clear & xfer_enable) != '0; endproperty
   property p_irq_pulse; cpu_irq |=> !cpu_irq; endproperty
   property p_irq_zero; cpu_irq |-> last_w_q == 16'h0000; endproperty
   a_ram_two: assert property (p_ram_two) else $error("on-chip access not two states");
   a_rf_word: assert property (p_rf_word) else $error("register field word not six states");
   a_rf_byte: assert property (p_rf_byte) else $error("register field byte not three states");
   a_stable: assert property (p_stable) else $error("memory request changed mid access");
   a_clr_onehot: assert property (p_clr_onehot) else $error("request clear not one-hot");
   a_clr_enabled: assert property (p_clr_enabled) else $error("clear of a disabled source");
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
   a_irq_zero: assert property (p_irq_zero) else $error("interrupt without zero count");
endmodule
bind te_engine te_engine_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .xfer_enable(xfer_enable),
   .req_clear(req_clear), .cpu_irq(cpu_irq), .mem_req(mem_req), .mem_addr(mem_addr), .mem_we(mem_we),
   .mem_word(mem_word), .mem_wdata(mem_wdata));

// ===== te_mem_model.sv
// memory bus partner model: byte array behind the engine's memory port
`timescale 1ns/1ps
module te_mem_model (
   input wire logic hclk,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic mem_we,
   input wire logic mem_word,
   input wire logic [15:0] mem_wdata,
   output logic [15:0] mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [15:0] junk_q = 16'hA5C3;
   // ==========================================
   // storage, big-endian words
   always @(posedge hclk) begin
      junk_q <= ~junk_q;
      if (mem_req && mem_we) begin
         mem[mem_addr] <= mem_word ? mem_wdata[15:8] : mem_wdata[7:0];
         if (mem_word)
            mem[mem_addr + 16'h0001] <= mem_wdata[7:0];
      end
   end
   // idle read lines toggle, never hold stale data
   always_comb begin
      if (!mem_req || mem_we)
         mem_rdata = junk_q;
      else if (mem_word)
         mem_rdata = {mem[mem_addr], mem[mem_addr + 16'h0001]};
      else
         mem_rdata = {junk_q[15:8], mem[mem_addr]};
   end
endmodule

// ===== te_pkg.sv
// constants, field layouts and shared helpers of the transfer engine
package te_pkg;
   // ==========================================
   // sources and pointer table
   localparam int NSRC = 17;
   localparam logic [4:0] SRC_LAST = 5'h10;
   localparam logic [15:0] PTR_MAX_SKIP = 16'h0002;
   // ==========================================
   // address regions
   localparam logic [15:0] ROM_HI = 16'h3FFF;
   localparam logic [15:0] RAM_LO = 16'hFD80;
   localparam logic [15:0] RAM_HI = 16'hFF7F;
   // ==========================================
   // descriptor layout
   localparam logic [15:0] DESC_MODE = 16'h0000;
   localparam logic [15:0] DESC_SRC = 16'h0002;
   localparam logic [15:0] DESC_DST = 16'h0004;
   localparam logic [15:0] DESC_CNT = 16'h0006;
   localparam int MODE_SIZE_BIT = 15;
   localparam int MODE_SI_BIT = 14;
   localparam int MODE_DI_BIT = 13;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [15:0] CNT_DEC = 16'h0001;
   // ==========================================
   // state counts
   localparam logic [7:0] ST_BASE = 8'h1A;
   localparam logic [7:0] ST_STEP = 8'h02;
   localparam logic [7:0] EXT_BASE = 8'h14;
   localparam logic [7:0] EXT_STEP = 8'h04;
   localparam logic [7:0] ACC_ONCHIP = 8'h02;
   localparam logic [7:0] ACC_EXT_WORD = 8'h06;
   localparam logic [7:0] ACC_EXT_BYTE = 8'h03;
   localparam logic [7:0] ARB_STATES = 8'h02;
   localparam logic [7:0] INSN_ONCHIP = 8'h26;
   localparam logic [7:0] INSN_EXT_BASE = 8'h4A;
   localparam logic [7:0] INSN_EXT_M = 8'h10;
   localparam logic [7:0] HND_MIN_ON = 8'h10;
   localparam logic [7:0] HND_MAX_ON = 8'h15;
   localparam logic [7:0] HND_MIN_EXT = 8'h1C;
   localparam logic [7:0] HND_MIN_EXT_M = 8'h06;
   localparam logic [7:0] HND_MAX_EXT = 8'h29;
   localparam logic [7:0] HND_MAX_EXT_M = 8'h0A;
   localparam logic [7:0] ONE8 = 8'h01;
   // ==========================================
   // register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DONE = 8'h08;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MAX_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int STAT_SRC_LO = 8;
   // ==========================================
   // helpers
   function automatic logic [15:0] slot_min(input logic [4:0] s);
      case (s)
         5'h00: slot_min = 16'h0080;
         5'h01: slot_min = 16'h0082;
         5'h02: slot_min = 16'h0084;
         5'h03: slot_min = 16'h0086;
         5'h04: slot_min = 16'h0090;
         5'h05: slot_min = 16'h0092;
         5'h06: slot_min = 16'h0094;
         5'h07: slot_min = 16'h0098;
         5'h08: slot_min = 16'h009A;
         5'h09: slot_min = 16'h009C;
         5'h0A: slot_min = 16'h00A0;
         5'h0B: slot_min = 16'h00A2;
         5'h0C: slot_min = 16'h00AA;
         5'h0D: slot_min = 16'h00AC;
         5'h0E: slot_min = 16'h00B2;
         5'h0F: slot_min = 16'h00B4;
         default: slot_min = 16'h00B8;
      endcase
   endfunction
   function automatic logic is_onchip(input logic [15:0] a);
      is_onchip = (a <= ROM_HI) || (a >= RAM_LO && a <= RAM_HI);
   endfunction
   function automatic logic [7:0] acc_cost(input logic [15:0] a, input logic w);
      if (is_onchip(a))
         acc_cost = ACC_ONCHIP;
      else
         acc_cost = w ? ACC_EXT_WORD : ACC_EXT_BYTE;
   endfunction
endpackage
